// file: inc/xba_pkg.sv
// Purpose: Shared constants and types for the exchange bus arbiter and sequencer
// Assumes: One 25 MHz clock; asynchronous active-high reset
// Notes:   Timing counts derive from nanosecond figures and the clock period
package xba_pkg;

  // ----------------------------------------
  // Tree shape
  // ----------------------------------------
  localparam int NUM_PORTS      = 24;
  localparam int PORTS_PER_MOD  = 4;
  localparam int NUM_PORT_MODS  = 6;
  localparam int MODS_PER_GROUP = 3;
  localparam int NUM_GROUPS     = 2;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_PERIOD_NS    = 40;
  localparam int CYCLE_TIMEOUT_NS = 10000;
  localparam int TIMEOUT_CYC      = CYCLE_TIMEOUT_NS / CLK_PERIOD_NS;
  localparam int TIMER_W          = 16;

  // ----------------------------------------
  // State types
  // ----------------------------------------
  typedef enum logic [1:0] {
    XBA_SCAN,
    XBA_HELD,
    XBA_GRANT
  } xba_arb_st_t;

  typedef enum logic [2:0] {
    XBA_IDLE,
    XBA_TIMING,
    XBA_RELEASE,
    XBA_BUSY,
    XBA_ACK_HI,
    XBA_ACK_LO
  } xba_seq_st_t;

endpackage : xba_pkg

// file: rtl/xba_arbiter.sv
// Purpose: Exchange bus arbiter tree plus bus cycle sequencer and cycle timer
// Assumes: Port lines synchronous to clk_i; acknowledge is a shared wired line
// Notes:   Port grants are registered, so grants reach ports one cycle after decode
`timescale 1ns/1ps
module xba_arbiter
  import xba_pkg::*;
#(
  parameter int TIMEOUT_CYCLES = TIMEOUT_CYC
) (
  input  wire logic                 clk_i,              // Clock, 25 MHz
  input  wire logic                 rst_i,              // Async reset, active high
  input  wire logic [NUM_PORTS-1:0] port_bus_request_i, // Per-port bus requests
  output logic      [NUM_PORTS-1:0] port_bus_grant_o,   // Per-port bus grants
  input  wire logic                 cycle_active_i,     // Cycle-active line
  input  wire logic                 receiver_engage_i,  // Receiver-engage line
  input  wire logic                 cycle_ack_i,        // Acknowledge line level
  output logic                      cycle_ack_o,        // Acknowledge drive value
  output logic                      cycle_ack_oe_o,     // Acknowledge drive enable
  output logic                      granted_o,          // Grant-issued line
  output logic                      grant_output_en_o,  // Grant output enable
  output logic                      release_queue_o,    // Release and queue
  output logic                      timer_run_o,        // Cycle timer running
  output logic                      timeout_o           // Cycle timer expired
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    xba_seq_st_t          st;
    logic [TIMER_W-1:0]   tmr;
    logic                 tmo;
    logic [NUM_PORTS-1:0] grant;
    logic                 granted;
    logic                 grant_output_enable;
    logic                 release_q;
    logic                 run;
    logic                 ack;
    logic                 ack_oe;
  } xba_seq_state_t;

  xba_seq_state_t s_q;
  xba_seq_state_t s_d;

  logic [NUM_PORTS-1:0]     port_grant_c;
  logic [NUM_PORT_MODS-1:0] port_level_request;
  logic [NUM_PORT_MODS-1:0] port_level_grant;
  logic [NUM_GROUPS-1:0]    group_level_request;
  logic [NUM_GROUPS-1:0]    group_level_grant;
  logic                     cycle_idle;

  // ----------------------------------------
  // Arbitration tree
  // ----------------------------------------
  // Port modules, four ports each, under enable
  for (genvar m = 0; m < NUM_PORT_MODS; m++) begin : g_port
    xba_scan_arb #(
      .N (PORTS_PER_MOD)
    ) u_port (
      .clk_i      (clk_i),
      .rst_i      (rst_i),
      .req_i      (port_bus_request_i[m*PORTS_PER_MOD +: PORTS_PER_MOD]),
      .up_grant_i (port_level_grant[m]),
      .en_i       (s_q.grant_output_enable),
      .release_i  (s_q.release_q),
      .fwd_req_o  (port_level_request[m]),
      .grant_o    (port_grant_c[m*PORTS_PER_MOD +: PORTS_PER_MOD])
    );
  end

  // Group modules, three port modules each
  for (genvar g = 0; g < NUM_GROUPS; g++) begin : g_group
    xba_scan_arb #(
      .N (MODS_PER_GROUP)
    ) u_group (
      .clk_i      (clk_i),
      .rst_i      (rst_i),
      .req_i      (port_level_request[g*MODS_PER_GROUP +: MODS_PER_GROUP]),
      .up_grant_i (group_level_grant[g]),
      .en_i       (1'b1),
      .release_i  (s_q.release_q),
      .fwd_req_o  (group_level_request[g]),
      .grant_o    (port_level_grant[g*MODS_PER_GROUP +: MODS_PER_GROUP])
    );
  end

  // Master module over both groups
  xba_scan_arb #(
    .N (NUM_GROUPS)
  ) u_master (
    .clk_i      (clk_i),
    .rst_i      (rst_i),
    .req_i      (group_level_request),
    .up_grant_i (1'b1),
    .en_i       (1'b1),
    .release_i  (s_q.release_q),
    .fwd_req_o  (),
    .grant_o    (group_level_grant)
  );

  // ----------------------------------------
  // Cycle sequencer and timer
  // ----------------------------------------
  // All three control lines quiet means the cycle is over
  assign cycle_idle = !cycle_active_i && !receiver_engage_i && !cycle_ack_i;

  always_comb begin
    s_d = s_q;
    // Grants captured into flops; grant-issued follows the same edge
    s_d.grant   = port_grant_c;
    s_d.granted = |port_grant_c;
    // Timer counts only while run is high, cleared otherwise
    if (s_q.run) begin
      if (s_q.tmr != TIMER_W'(TIMEOUT_CYCLES - 1)) begin
        s_d.tmr = s_q.tmr + 1'b1;
      end
    end else begin
      s_d.tmr = '0;
    end
    s_d.tmo = s_q.run && (s_q.tmr == TIMER_W'(TIMEOUT_CYCLES - 1));
    case (s_q.st)
      XBA_IDLE: begin
        if (s_q.granted) begin
          s_d.st = XBA_TIMING;
        end
      end
      XBA_TIMING: begin
        if (cycle_active_i || s_q.tmo) begin
          s_d.st = XBA_RELEASE;
        end
      end
      XBA_RELEASE: begin
        if (!s_q.granted) begin
          s_d.st = XBA_BUSY;
        end
      end
      XBA_BUSY: begin
        if (s_q.tmo) begin
          s_d.st = XBA_ACK_HI;
        end else if (cycle_idle) begin
          s_d.st = XBA_IDLE;
        end
      end
      XBA_ACK_HI: begin
        if (!cycle_active_i) begin
          s_d.st = XBA_ACK_LO; // Transmitter closed its side
        end
      end
      XBA_ACK_LO: begin
        s_d.st = XBA_IDLE;
      end
      default: s_d.st = XBA_IDLE;
    endcase
    // Control lines follow the next state
    s_d.grant_output_enable     = (s_d.st == XBA_IDLE) || (s_d.st == XBA_TIMING) ||
                    (s_d.st == XBA_RELEASE);
    s_d.release_q = (s_d.st == XBA_RELEASE);
    s_d.run       = (s_d.st == XBA_TIMING) || (s_d.st == XBA_RELEASE) ||
                    (s_d.st == XBA_BUSY);
    s_d.ack       = (s_d.st == XBA_ACK_HI);
    s_d.ack_oe    = (s_d.st == XBA_ACK_HI) || (s_d.st == XBA_ACK_LO);
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      s_q <= '{st: XBA_IDLE, tmr: '0, tmo: 1'b0, grant: '0, granted: 1'b0,
               grant_output_enable: 1'b1, release_q: 1'b0, run: 1'b0, ack: 1'b0, ack_oe: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign port_bus_grant_o  = s_q.grant;
  assign granted_o         = s_q.granted;
  assign grant_output_en_o = s_q.grant_output_enable;
  assign release_queue_o   = s_q.release_q;
  assign timer_run_o       = s_q.run;
  assign timeout_o         = s_q.tmo;
  assign cycle_ack_o       = s_q.ack;
  assign cycle_ack_oe_o    = s_q.ack_oe;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  chk_idle_lines: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (s_q.st == XBA_IDLE) |-> (s_q.grant_output_enable && !s_q.release_q && !s_q.run))
    else $error("idle bus lines wrong");

  chk_grant_starts: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (s_q.st == XBA_IDLE && s_q.granted) |=> (s_q.st == XBA_TIMING && s_q.run && !s_q.release_q))
    else $error("timer not started on grant issued");

  chk_ca_release: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (s_q.st == XBA_TIMING && cycle_active_i) |=> s_q.release_q)
    else $error("release not raised on cycle active");

  chk_release_drop: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (s_q.release_q && !s_q.granted) |=> (!s_q.release_q && !s_q.grant_output_enable))
    else $error("release or enable not dropped");

  chk_cycle_done: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (s_q.st == XBA_BUSY && !s_q.tmo && cycle_idle) |=> (s_q.grant_output_enable && !s_q.run) ##1 (s_q.tmr == '0))
    else $error("completion did not reset timer and enable");

  chk_timeout_ack: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (s_q.st == XBA_BUSY && s_q.tmo) |=> (cycle_ack_oe_o && cycle_ack_o && !s_q.grant_output_enable))
    else $error("timeout did not drive acknowledge");

  chk_one_grant: assert property (
    @(posedge clk_i) disable iff (rst_i)
    $onehot0(s_q.grant))
    else $error("more than one port granted");

  chk_grant_enable: assert property (
    @(posedge clk_i) disable iff (rst_i)
    $rose(|s_q.grant) |-> $past(s_q.grant_output_enable))
    else $error("grant issued while enable low");

  chk_granted_line: assert property (
    @(posedge clk_i) disable iff (rst_i)
    s_q.granted == (|s_q.grant))
    else $error("grant issued line disagrees with grants");

  chk_timer_expiry: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (s_q.run && s_q.tmr == TIMER_W'(TIMEOUT_CYCLES - 1)) |=> (s_q.tmo || !s_q.run))
    else $error("timer expiry not reported");

endmodule : xba_arbiter

// file: rtl/xba_scan_arb.sv
// Purpose: One arbiter module of the tree: scans, latches, forwards, grants
// Assumes: Requests synchronous to clk_i
// Notes:   Forwarded request is combinational so requests climb without delay
`timescale 1ns/1ps
module xba_scan_arb
  import xba_pkg::*;
#(
  parameter int N = 4
) (
  input  wire logic         clk_i,      // Clock
  input  wire logic         rst_i,      // Async reset, active high
  input  wire logic [N-1:0] req_i,      // Request lines scanned
  input  wire logic         up_grant_i, // Grant from the level above
  input  wire logic         en_i,       // Grant output enable
  input  wire logic         release_i,  // Release and queue
  output logic              fwd_req_o,  // Request to the level above
  output logic      [N-1:0] grant_o     // Grant lines out
);

  localparam int PW = (N > 1) ? $clog2(N) : 1;

  typedef struct packed {
    xba_arb_st_t   st;
    logic [PW-1:0] ptr;
  } xba_arb_state_t;

  xba_arb_state_t s_q;
  xba_arb_state_t s_d;

  // ----------------------------------------
  // Forwarding and grant decode
  // ----------------------------------------
  // Any active request goes straight up, scanner or not
  assign fwd_req_o = |req_i;

  always_comb begin
    grant_o = '0;
    if (s_q.st == XBA_GRANT && up_grant_i && en_i) begin
      grant_o[s_q.ptr] = 1'b1;
    end
  end

  // ----------------------------------------
  // Scanner state
  // ----------------------------------------
  // Sequential scan; first active line found stops the scan
  always_comb begin
    s_d = s_q;
    case (s_q.st)
      XBA_SCAN: begin
        if (req_i[s_q.ptr]) begin
          s_d.st = XBA_HELD;
        end else if (s_q.ptr == PW'(N - 1)) begin
          s_d.ptr = '0;
        end else begin
          s_d.ptr = s_q.ptr + 1'b1;
        end
      end
      XBA_HELD: begin
        if (!req_i[s_q.ptr]) begin
          s_d.st = XBA_SCAN; // Requester withdrew before being served
        end else if (up_grant_i) begin
          s_d.st = XBA_GRANT;
        end
      end
      XBA_GRANT: begin
        if (release_i) begin
          s_d.st  = XBA_SCAN;
          s_d.ptr = (s_q.ptr == PW'(N - 1)) ? '0 : s_q.ptr + 1'b1;
        end
      end
      default: s_d.st = XBA_SCAN;
    endcase
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      s_q <= '{st: XBA_SCAN, ptr: '0};
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  chk_grant_needs_up: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (|grant_o) |-> (up_grant_i && en_i && $onehot(grant_o)))
    else $error("grant out without upper grant or enable");

  chk_hold_until_release: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (s_q.st == XBA_GRANT && !release_i) |=> (s_q.st == XBA_GRANT && $stable(s_q.ptr)))
    else $error("granting state left without release");

endmodule : xba_scan_arb

// file: tb/tb.sv
// Purpose: Self-checking bench for the exchange bus arbiter and sequencer
// Assumes: Inputs driven at the falling edge; outputs sampled there too
// Notes:   Timeout shortened through the parameter to keep the run brief
`timescale 1ns/1ps
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin failures++; \
  $display("Error at %0t: got %h expected %h", $time, (a), (e)); end end
`define WAIT(c, b) begin for (k = 0; k < (b) && !(c); k++) @(negedge clk_i); \
  if (!(c)) begin failures++; summarize(); end end
module tb
  import xba_pkg::*;
;
  localparam int TO = 20;
  logic                 clk_i = 1'h0;
  logic                 rst_i = 1'h1;
  logic [NUM_PORTS-1:0] raise = '0;
  logic [NUM_PORTS-1:0] drop  = '0;
  logic [1:0]           mode  = 2'h0;
  logic [NUM_PORTS-1:0] req, grant, g1;
  logic                 ca, engage, m_ack, d_ack, d_oe, granted, en, rel, trun, tout;
  wire  logic           ack_w = m_ack | (d_oe & d_ack); // Wired acknowledge line
  int                   failures = 0;
  int                   n_compared = 0;
  int                   k, cnt;

  // ----------------------------------------
  // Clock, instances
  // ----------------------------------------
  always #20 clk_i = ~clk_i;

  xba_arbiter #(.TIMEOUT_CYCLES(TO)) u_xba_arbiter (
    .clk_i(clk_i), .rst_i(rst_i), .port_bus_request_i(req), .port_bus_grant_o(grant),
    .cycle_active_i(ca), .receiver_engage_i(engage), .cycle_ack_i(ack_w),
    .cycle_ack_o(d_ack), .cycle_ack_oe_o(d_oe), .granted_o(granted),
    .grant_output_en_o(en), .release_queue_o(rel), .timer_run_o(trun), .timeout_o(tout));

  xba_port_model u_xba_port_model (
    .clk_i(clk_i), .rst_i(rst_i), .raise_i(raise), .drop_i(drop), .mode_i(mode),
    .grant_i(grant), .ack_i(ack_w), .req_o(req), .ca_o(ca), .engage_o(engage), .ack_o(m_ack));

  // ----------------------------------------
  // Scenario tasks
  // ----------------------------------------
  task automatic summarize();
    $display("Compared %0d, failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : summarize

  task automatic pulse(input logic [NUM_PORTS-1:0] m);
    raise = m;
    @(negedge clk_i);
    raise = '0;
  endtask : pulse

  // One normal cycle on port n with every sequencer step checked
  task automatic run_cycle(input int n);
    mode = 2'h0;
    pulse(NUM_PORTS'(1) << n);
    `WAIT(|grant, 60)
    `CHK(grant, NUM_PORTS'(1) << n)
    `CHK(granted, 1'h1)
    `CHK(en, 1'h1)
    @(negedge clk_i);
    `CHK(trun, 1'h1)
    `WAIT(rel, 40)
    `CHK(ca, 1'h1)
    `WAIT(!granted, 10)
    `CHK(grant, '0)
    @(negedge clk_i);
    `CHK(rel, 1'h0)
    `CHK(en, 1'h0)
    `WAIT(en, 20)
    `CHK(trun, 1'h0)
  endtask : run_cycle

  // Two requests at once: one waits queued for the enable
  task automatic queued_pair();
    logic [NUM_PORTS-1:0] both;
    both = NUM_PORTS'(1) | (NUM_PORTS'(1) << 23);
    mode = 2'h0;
    pulse(both);
    `WAIT(|grant, 60)
    g1 = grant;
    `CHK((g1 == NUM_PORTS'(1)) || (g1 == (NUM_PORTS'(1) << 23)), 1'h1)
    `WAIT(!en, 40)
    for (k = 0; k < 6 && !en; k++) begin
      `CHK(grant, '0)
      @(negedge clk_i);
    end
    `WAIT(|grant, 20)
    `CHK(grant, both ^ g1)
    `CHK(en, 1'h1)
    `WAIT(en && !granted && !trun, 80)
  endtask : queued_pair

  // Cycle started but no receiver: sequencer supplies the acknowledge
  task automatic busy_timeout();
    mode = 2'h1;
    pulse(NUM_PORTS'(1) << 5);
    `WAIT(d_oe, 200)
    `CHK(d_ack, 1'h1)
    `CHK(en, 1'h0)
    `WAIT(!d_oe, 20)
    `CHK(en, 1'h1)
    `CHK(trun, 1'h0)
    mode = 2'h0;
  endtask : busy_timeout

  // Granted port never starts: timer length and recovery
  task automatic mute_timeout();
    mode = 2'h2;
    pulse(NUM_PORTS'(1) << 10);
    `WAIT(|grant, 60)
    drop = NUM_PORTS'(1) << 10;
    cnt = 0;
    for (k = 0; k < 200 && !tout; k++) begin
      @(negedge clk_i);
      cnt += int'(trun);
    end
    `CHK(tout, 1'h1)
    `CHK((cnt >= TO - 3) && (cnt <= TO + 3), 1'h1)
    `WAIT(en && !granted && !trun, 200)
    `CHK(grant, '0)
    drop = '0;
    mode = 2'h0;
  endtask : mute_timeout

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (10) @(negedge clk_i);
    rst_i = 1'h0;
    @(negedge clk_i);
    `CHK(en, 1'h1)
    `CHK(granted, 1'h0)
    `CHK(rel, 1'h0)
    `CHK(grant, '0)
    for (int p = NUM_PORTS - 1; p >= 0; p--) begin
      run_cycle(p);
    end
    queued_pair();
    busy_timeout();
    mute_timeout();
    run_cycle(0);
    summarize();
  end
endmodule : tb

// file: tb/xba_port_model.sv
// Purpose: Behavioural ports on the far side of the arbiter: requesters and receivers
// Assumes: One clock; control lines are pulled inactive when nobody drives them
// Notes:   Mode 0 normal cycle, mode 1 no receiver engages, mode 2 granted port stays mute
`timescale 1ns/1ps
module xba_port_model
  import xba_pkg::*;
(
  input  wire logic [0:0]           clk_i,    // Clock
  input  wire logic                 rst_i,    // Async reset, active high
  input  wire logic [NUM_PORTS-1:0] raise_i,  // Requests to raise
  input  wire logic [NUM_PORTS-1:0] drop_i,   // Requests to withdraw
  input  wire logic [1:0]           mode_i,   // Behaviour of the granted port
  input  wire logic [NUM_PORTS-1:0] grant_i,  // Grants from the arbiter
  input  wire logic                 ack_i,    // Resolved acknowledge wire
  output logic      [NUM_PORTS-1:0] req_o,    // Port requests
  output logic                      ca_o,     // Cycle-active drive
  output logic                      engage_o, // Receiver-engage drive
  output logic                      ack_o     // Receiver acknowledge drive
);
  logic [1:0]           ph_q;
  logic [2:0]           dwell_q;
  logic [NUM_PORTS-1:0] start_c;

  // Granted port that opens its cycle at this edge
  assign start_c = (ph_q == 2'h0 && mode_i != 2'h2) ? (grant_i & req_o) : '0;

  // ----------------------------------------
  // Transmitter and receiver sequence
  // ----------------------------------------
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      req_o    <= '0;
      ca_o     <= 1'h0;
      engage_o <= 1'h0;
      ack_o    <= 1'h0;
      ph_q     <= 2'h0;
      dwell_q  <= 3'h0;
    end else begin
      req_o <= (req_o | raise_i) & ~drop_i & ~start_c;
      case (ph_q)
        2'h0: if (|start_c) begin
          ca_o <= 1'h1;
          ph_q <= 2'h1;
        end
        2'h1: if (mode_i == 2'h0) begin
          engage_o <= 1'h1;
          ph_q     <= 2'h2;
        end else if (ack_i) begin
          ca_o <= 1'h0; // Transmitter finishes on the supplied acknowledge
          ph_q <= 2'h0;
        end
        // Receiver holds acknowledge a while, so the enable stays low long enough
        2'h2: begin
          ack_o   <= 1'h1;
          dwell_q <= dwell_q + 3'h1;
          if (dwell_q == 3'h7) begin
            ph_q <= 2'h3;
          end
        end
        default: begin
          ca_o     <= 1'h0;
          engage_o <= 1'h0;
          ack_o    <= 1'h0;
          ph_q     <= 2'h0;
        end
      endcase
    end
  end
endmodule : xba_port_model
